// [src/loop_status_defs.svh]
`ifndef LOOP_STATUS_DEFS_SVH
`define LOOP_STATUS_DEFS_SVH

`define LSW_SAVE_DONE_BIT 15
`define LSW_SENSOR_FAULT_BIT 14
`define LSW_FATAL_ERR_BIT 12
`define LSW_STANDBY_BIT 11
`define LSW_PID_READY_BIT 10
`define LSW_SETTING_ERR_BIT 9
`define LSW_STOPPED_BIT 8
`define LSW_CTRL_OUT_BIT 4
`define LSW_AUTOTUNE_BIT 3
`define LSW_FIRST_ALARM_BIT 1
`define LSW_SECOND_ALARM_BIT 0
`define LSW_RESET_VALUE 16'h0800
`define LSW_RESERVED_MASK 16'h20E4
`define LSW_FLAG_RESET_VALUE 1'b0

`endif

// [src/loop_status_pkg.sv]
package loop_status_pkg;
  typedef enum logic [1:0] {ST_STANDBY, ST_RUN} phase_e;
  typedef logic [15:0] status_word_t;
endpackage : loop_status_pkg

// [src/loop_status_word.sv]
`timescale 1ns/1ps
`default_nettype none
`include "loop_status_defs.svh"

// Inclusive signed window; an inverted window never matches
module lsw_range_check #(
  parameter int WIDTH = 16
) (
  input wire logic signed [WIDTH-1:0] value_i,
  input wire logic signed [WIDTH-1:0] low_i,
  input wire logic signed [WIDTH-1:0] high_i,
  output logic inside_o
);

  if (WIDTH < 2) begin : g_width_check
    $error("lsw_range_check: WIDTH must be at least 2");
  end

  logic at_or_above_low;
  logic at_or_below_high;

  assign at_or_above_low = (value_i >= low_i);
  assign at_or_below_high = (value_i <= high_i);
  assign inside_o = at_or_above_low && at_or_below_high;

endmodule : lsw_range_check

// Event flag; set wins when set and clear share a cycle
module lsw_sticky_flag (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_next_o
);

  typedef struct packed {
    logic flag;
  } sticky_s;

  sticky_s state_q;
  sticky_s state_d;

  always_comb begin
    state_d = state_q;
    if (set_i) begin
      state_d.flag = 1'b1;
    end else if (clear_i) begin
      state_d.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q.flag <= `LSW_FLAG_RESET_VALUE;
    end else begin
      state_q <= state_d;
    end
  end

  // Next value, so the word register picks it up on the same edge
  assign flag_next_o = state_d.flag;

endmodule : lsw_sticky_flag

module loop_status_word
  import loop_status_pkg::*;
#(
  parameter int TEMP_WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic signed [TEMP_WIDTH-1:0] temperature_i,
  input wire logic signed [TEMP_WIDTH-1:0] input_min_i,
  input wire logic signed [TEMP_WIDTH-1:0] input_max_i,
  input wire logic sensor_open_i,
  input wire logic cold_junction_fault_i,
  input wire logic host_watchdog_timeout_i,
  input wire logic host_refresh_i,
  input wire logic pid_constants_updated_i,
  input wire logic pid_constants_transferred_i,
  input wire logic setting_error_i,
  input wire logic control_stopped_i,
  input wire logic control_output_i,
  input wire logic autotune_active_i,
  input wire logic signed [TEMP_WIDTH-1:0] first_alarm_low_i,
  input wire logic signed [TEMP_WIDTH-1:0] first_alarm_high_i,
  input wire logic signed [TEMP_WIDTH-1:0] second_alarm_low_i,
  input wire logic signed [TEMP_WIDTH-1:0] second_alarm_high_i,
  input wire logic save_request_i,
  input wire logic save_finished_i,
  output logic [15:0] loop_status_word_o
);

  localparam int WORD_WIDTH = 16;
  localparam int FLAG_COUNT = 11;
  // Reset shows only standby
  localparam status_word_t RESET_WORD = `LSW_RESET_VALUE;

  // Flag positions, checked against the word and the reserved bits
  localparam int FLAG_POS [FLAG_COUNT] = '{
    `LSW_SAVE_DONE_BIT,
    `LSW_SENSOR_FAULT_BIT,
    `LSW_FATAL_ERR_BIT,
    `LSW_STANDBY_BIT,
    `LSW_PID_READY_BIT,
    `LSW_SETTING_ERR_BIT,
    `LSW_STOPPED_BIT,
    `LSW_CTRL_OUT_BIT,
    `LSW_AUTOTUNE_BIT,
    `LSW_FIRST_ALARM_BIT,
    `LSW_SECOND_ALARM_BIT
  };

  if (TEMP_WIDTH < 2) begin : g_temp_width_check
    $error("loop_status_word: TEMP_WIDTH must be at least 2");
  end

  if ($bits(status_word_t) != WORD_WIDTH) begin : g_word_width_check
    $error("loop_status_word: status word type must be 16 bits");
  end

  if ((RESET_WORD & `LSW_RESERVED_MASK) != 16'h0000) begin : g_reset_value_check
    $error("loop_status_word: reset value touches reserved bits");
  end

  if (RESET_WORD != (16'h0001 << `LSW_STANDBY_BIT)) begin : g_reset_standby_check
    $error("loop_status_word: reset value must show standby only");
  end

  for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag_pos
    if (FLAG_POS[i] >= WORD_WIDTH) begin : g_outside
      $error("loop_status_word: flag position outside the word");
    end else if (((`LSW_RESERVED_MASK >> FLAG_POS[i]) & 1) != 0) begin : g_clash
      $error("loop_status_word: flag position on a reserved bit");
    end
  end

  // Single-bit flag sources feeding the snapshot
  logic input_in_range;
  logic out_of_range;
  logic sensor_fault;
  logic fatal_error;
  logic first_alarm_hit;
  logic second_alarm_hit;
  logic pid_ready_next;
  logic save_done_next;

  lsw_range_check #(
    .WIDTH(TEMP_WIDTH)
  ) u_input_range (
    .value_i(temperature_i),
    .low_i(input_min_i),
    .high_i(input_max_i),
    .inside_o(input_in_range)
  );

  lsw_range_check #(
    .WIDTH(TEMP_WIDTH)
  ) u_first_alarm (
    .value_i(temperature_i),
    .low_i(first_alarm_low_i),
    .high_i(first_alarm_high_i),
    .inside_o(first_alarm_hit)
  );

  lsw_range_check #(
    .WIDTH(TEMP_WIDTH)
  ) u_second_alarm (
    .value_i(temperature_i),
    .low_i(second_alarm_low_i),
    .high_i(second_alarm_high_i),
    .inside_o(second_alarm_hit)
  );

  // Bit 10: a fresh result beats the transfer strobe so none is lost
  lsw_sticky_flag u_pid_ready (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(pid_constants_updated_i),
    .clear_i(pid_constants_transferred_i),
    .flag_next_o(pid_ready_next)
  );

  // Bit 15: completion beats a request raised in the same cycle
  lsw_sticky_flag u_save_done (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(save_finished_i),
    .clear_i(save_request_i),
    .flag_next_o(save_done_next)
  );

  assign out_of_range = !input_in_range;
  assign sensor_fault = sensor_open_i || out_of_range;
  assign fatal_error = cold_junction_fault_i || host_watchdog_timeout_i;

  // Places every flag; reserved bits are forced low last
  function automatic status_word_t pack_word(
    input logic save_done,
    input logic sensor_flt,
    input logic fatal_err,
    input logic standby,
    input logic pid_ready,
    input logic setting_err,
    input logic stopped,
    input logic ctrl_out,
    input logic tuning,
    input logic first_hit,
    input logic second_hit
  );
    status_word_t word;
    word = '0;
    word[`LSW_SAVE_DONE_BIT] = save_done;
    word[`LSW_SENSOR_FAULT_BIT] = sensor_flt;
    word[`LSW_FATAL_ERR_BIT] = fatal_err;
    word[`LSW_STANDBY_BIT] = standby;
    word[`LSW_PID_READY_BIT] = pid_ready;
    word[`LSW_SETTING_ERR_BIT] = setting_err;
    word[`LSW_STOPPED_BIT] = stopped;
    word[`LSW_CTRL_OUT_BIT] = ctrl_out;
    word[`LSW_AUTOTUNE_BIT] = tuning;
    word[`LSW_FIRST_ALARM_BIT] = first_hit;
    word[`LSW_SECOND_ALARM_BIT] = second_hit;
    word = word & ~`LSW_RESERVED_MASK;
    return word;
  endfunction : pack_word

  // Phase and word share one register
  typedef struct packed {
    phase_e phase;
    status_word_t word;
  } state_s;

  state_s state_q;
  state_s state_d;

  always_comb begin
    state_d = state_q;
    // Standby lasts until the first host refresh
    case (state_q.phase)
      ST_STANDBY: begin
        if (host_refresh_i) begin
          state_d.phase = ST_RUN;
        end else begin
          state_d.phase = ST_STANDBY;
        end
      end
      ST_RUN: begin
        // Only a reset brings standby back
        state_d.phase = ST_RUN;
      end
      default: begin
        state_d.phase = ST_STANDBY;
      end
    endcase
    state_d.word = pack_word(
      save_done_next,
      sensor_fault,
      fatal_error,
      (state_d.phase == ST_STANDBY),
      pid_ready_next,
      setting_error_i,
      control_stopped_i,
      control_output_i,
      autotune_active_i,
      first_alarm_hit,
      second_alarm_hit
    );
  end

  // One register for the whole word keeps the snapshot coherent
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q.phase <= ST_STANDBY;
      state_q.word <= RESET_WORD;
    end else begin
      state_q <= state_d;
    end
  end

  assign loop_status_word_o = state_q.word;

endmodule : loop_status_word
`default_nettype wire

// [verification/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [15:0] word_i,
  output logic [2:0] act_o
);
  // Acts a cycle late; acks only flags it has seen, refreshes whenever go_i is high
  initial act_o = 3'b000;
  always @(negedge clk_i) act_o <= {3{go_i}} & {1'b1, word_i[10], word_i[15]};
endmodule : host_model
`default_nettype wire

// [verification/lsw_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module lsw_properties (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic host_refresh_i,
  input wire logic control_stopped_i,
  input wire logic save_request_i,
  input wire logic save_finished_i,
  input wire logic [15:0] loop_status_word_o
);
  wire [15:0] w = loop_status_word_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence save_walk; save_finished_i ##1 save_request_i && !save_finished_i; endsequence
  a_reserved_zero: assert property ((w & 16'h20e4) == 0) else $error("reserved");
  a_stop_flag: assert property (1 |=> w[8] == $past(control_stopped_i)) else $error("stop");
  a_standby_holds: assert property (w[11] && !host_refresh_i |=> w[11]) else $error("wait");
  a_standby_ends: assert property (host_refresh_i |=> !w[11]) else $error("ends");
  a_standby_gone: assert property (!w[11] |=> !w[11]) else $error("back");
  a_save_done: assert property (save_finished_i |=> w[15]) else $error("done");
  a_save_walk: assert property (save_walk |=> !w[15]) else $error("clear");
  a_save_hold: assert property (!save_request_i && !save_finished_i |=> $stable(w[15]))
    else $error("hold");
endmodule : lsw_properties
bind loop_status_word lsw_properties u_props (.*);
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 0, sys_rst_i = 1, go = 0;
  logic [8:0] b = 0;
  logic signed [15:0] v [7] = '{default: 0};
  logic [15:0] e, loop_status_word_o;
  int seed = 97227, err_count = 0, n_compared = 0, cyc = 0;
  wire sensor_open_i = b[0], cold_junction_fault_i = b[1], host_watchdog_timeout_i = b[2];
  wire pid_constants_updated_i = b[3], control_stopped_i = b[4], setting_error_i = b[5];
  wire autotune_active_i = b[6], control_output_i = b[7], save_finished_i = b[8];
  wire signed [15:0] temperature_i = v[0], input_min_i = v[1], input_max_i = v[2];
  wire signed [15:0] first_alarm_low_i = v[3], first_alarm_high_i = v[4];
  wire signed [15:0] second_alarm_low_i = v[5], second_alarm_high_i = v[6];
  wire host_refresh_i, save_request_i, pid_constants_transferred_i;
  loop_status_word u_dut (.*);
  host_model u_host (.clk_i, .go_i(go), .word_i(loop_status_word_o),
    .act_o({host_refresh_i, pid_constants_transferred_i, save_request_i}));
  always #5 clk_i = ~clk_i;
  // Reference word; set beats clear on bits 15 and 10
  always @(posedge clk_i) e = sys_rst_i ? 16'h0800 : {b[8] | e[15] & !save_request_i,
    b[0] | v[0] < v[1] | v[0] > v[2], 1'b0, b[1] | b[2], e[11] & !host_refresh_i,
    b[3] | e[10] & !pid_constants_transferred_i, b[5:4], 3'b000, b[7:6], 1'b0,
    v[3] <= v[0] && v[0] <= v[4], v[5] <= v[0] && v[0] <= v[6]};
  always @(negedge clk_i) begin
    n_compared++;
    if (loop_status_word_o !==
        e) begin
      err_count++;
      $display("FAIL %0t got %h want %h", $time, loop_status_word_o, e);
    end
    b = 9'($random(seed) & $random(seed));
    foreach (v[i]) v[i] = 16'($random(seed) % 24);
    if (++cyc == 1500) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (20) @(negedge clk_i);
    go = 1;
    repeat (500) @(negedge clk_i);
    sys_rst_i = 1;
    repeat (4) @(negedge clk_i);
    sys_rst_i = 0;
    repeat (300) @(negedge clk_i);
    complete_run();
  end
endmodule : tb
`default_nettype wire
